/* File: logic/ltvs_regs.sv */
// ltvs_regs: thermal / output-voltage control register, silicon revision register and
// strobe gating of the flash driver.
// assumes the serial interface presents a byte register port (addr, wdata, wr, rd pulses,
// rdata sampled the cycle after rd) on i_clk; comparator and strobe inputs are async.
//
// Notes on behaviour
// - bit 7 enables temperature monitoring, reset off
// - bit 6 hot flag, cleared by writing zero
// - bit 5 warning flag, cleared after read
// - bit 4 headroom status sampled at flash end
// - bits 3:0 read back calibration result code
// - bits 3:0 write target voltage, reset 1001
// - code maps 3.825 V to 5.700 V
// - register 0x07 returns three-bit revision id
// - light commanded by registers or strobe pins
// - safety timer cuts off long flash
// - strobe b high disables torch watchdog
// - hot flag latches device into shutdown
// - thermal register sits at address 0x06
`timescale 1ns/1ps
module ltvs_regs (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic        i_hot_cmp,
    input  wire logic        i_warn_cmp,
    input  wire logic        i_headroom_cmp,
    input  wire logic [3:0]  i_cal_code,
    input  wire logic        i_cal_done,
    input  wire logic        i_strobe_input_a,
    input  wire logic        i_strobe_input_b,
    input  wire logic        i_sw_flash,
    input  wire logic        i_sw_torch,
    input  wire logic [7:0]  i_flash_safety_timer_ticks,
    output logic [7:0]       o_rdata,
    output logic             o_temp_monitor_enable,
    output logic             o_shutdown,
    output logic [3:0]       o_output_voltage_code,
    output logic             o_flash_on,
    output logic             o_torch_on
);
    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers: a change counts once stages two and three agree
    logic [2:0] hot_sy_ff, warn_sy_ff, hdr_sy_ff, sa_sy_ff, sb_sy_ff;
    logic       hot_ff, warn_ff, hdr_ff, sa_ff, sb_ff;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hot_sy_ff  <= 3'h0;
            warn_sy_ff <= 3'h0;
            hdr_sy_ff  <= 3'h0;
            sa_sy_ff   <= 3'h0;
            sb_sy_ff   <= 3'h0;
        end else begin
            hot_sy_ff  <= {hot_sy_ff[1:0], i_hot_cmp};
            warn_sy_ff <= {warn_sy_ff[1:0], i_warn_cmp};
            hdr_sy_ff  <= {hdr_sy_ff[1:0], i_headroom_cmp};
            sa_sy_ff   <= {sa_sy_ff[1:0], i_strobe_input_a};
            sb_sy_ff   <= {sb_sy_ff[1:0], i_strobe_input_b};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hot_ff  <= 1'b0;
            warn_ff <= 1'b0;
            hdr_ff  <= 1'b0;
            sa_ff   <= 1'b0;
            sb_ff   <= 1'b0;
        end else begin
            if (hot_sy_ff[1] == hot_sy_ff[2]) begin
                hot_ff <= hot_sy_ff[2];
            end
            if (warn_sy_ff[1] == warn_sy_ff[2]) begin
                warn_ff <= warn_sy_ff[2];
            end
            if (hdr_sy_ff[1] == hdr_sy_ff[2]) begin
                hdr_ff <= hdr_sy_ff[2];
            end
            if (sa_sy_ff[1] == sa_sy_ff[2]) begin
                sa_ff <= sa_sy_ff[2];
            end
            if (sb_sy_ff[1] == sb_sy_ff[2]) begin
                sb_ff <= sb_sy_ff[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register decode
    logic wr_tv, rd_tv, rd_rev;
    assign wr_tv  = i_wr && (i_addr == ltvs_pkg::ADDR_THERM_VOUT);
    assign rd_tv  = i_rd && (i_addr == ltvs_pkg::ADDR_THERM_VOUT);
    assign rd_rev = i_rd && (i_addr == ltvs_pkg::ADDR_SI_REV);

    logic       temp_monitor_enable_ff;
    logic       over_temperature_flag_ff;
    logic       temperature_warning_flag_ff;
    logic       regulator_headroom_ok_ff;
    logic [3:0] output_voltage_code_ff;
    logic [3:0] cal_result_ff;
    logic       flash_end;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            temp_monitor_enable_ff <= 1'b0;
        end else if (wr_tv) begin
            temp_monitor_enable_ff <= i_wdata[ltvs_pkg::BIT_TEMP_MON_EN];
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            over_temperature_flag_ff <= 1'b0;
        end else if (temp_monitor_enable_ff && hot_ff) begin
            over_temperature_flag_ff <= 1'b1;
        end else if (wr_tv && !i_wdata[ltvs_pkg::BIT_OVER_TEMP]) begin
            over_temperature_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            temperature_warning_flag_ff <= 1'b0;
        end else if (temp_monitor_enable_ff && warn_ff) begin
            temperature_warning_flag_ff <= 1'b1;
        end else if (rd_tv) begin
            temperature_warning_flag_ff <= 1'b0;
        end
    end

    // headroom is only meaningful at the end of the flash plateau
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            regulator_headroom_ok_ff <= 1'b0;
        end else if (flash_end) begin
            regulator_headroom_ok_ff <= hdr_ff;
        end
    end

    // target written by the host, or a calibration result, drives the regulator; the readback is the calibration
    // result, which starts at the target so an uncalibrated part reads what was set
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            output_voltage_code_ff <= ltvs_pkg::VOUT_CODE_RST;
        end else if (i_cal_done) begin
            output_voltage_code_ff <= i_cal_code;
        end else if (wr_tv) begin
            output_voltage_code_ff <= i_wdata[3:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cal_result_ff <= ltvs_pkg::VOUT_CODE_RST;
        end else if (i_cal_done) begin
            cal_result_ff <= i_cal_code;
        end else if (wr_tv) begin
            cal_result_ff <= i_wdata[3:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= ltvs_pkg::RD_ZERO;
        end else if (rd_tv) begin
            o_rdata <= {temp_monitor_enable_ff, over_temperature_flag_ff,
                        temperature_warning_flag_ff, regulator_headroom_ok_ff,
                        cal_result_ff};
        end else if (rd_rev) begin
            o_rdata <= {5'h00, ltvs_pkg::SI_REV_ID};
        end else if (i_rd) begin
            o_rdata <= ltvs_pkg::RD_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // millisecond tick for the timers
    logic [13:0] div_ff;
    logic        tick_ff;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_ff  <= 14'h0000;
            tick_ff <= 1'b0;
        end else if (div_ff == ltvs_pkg::TICK_CYC_W - 14'h0001) begin
            div_ff  <= 14'h0000;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + 14'h0001;
            tick_ff <= 1'b0;
        end
    end

    ltvs_strobe_if sif ();
    assign sif.flash_req  = sa_ff || i_sw_flash;
    assign sif.torch_req  = sb_ff || i_sw_torch;
    assign sif.wdog_off   = sb_ff;
    assign sif.shutdown   = over_temperature_flag_ff;
    assign sif.flash_safety_timer_ticks = i_flash_safety_timer_ticks;
    assign sif.tick       = tick_ff;
    assign flash_end      = sif.flash_end;

    ltvs_flash_seq u_seq (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .s       (sif)
    );

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_flash_on            <= 1'b0;
            o_torch_on            <= 1'b0;
            o_shutdown            <= 1'b0;
            o_temp_monitor_enable <= 1'b0;
            o_output_voltage_code <= ltvs_pkg::VOUT_CODE_RST;
        end else begin
            o_flash_on            <= sif.flash_on && !over_temperature_flag_ff;
            o_torch_on            <= sif.torch_on && !over_temperature_flag_ff;
            o_shutdown            <= over_temperature_flag_ff;
            o_temp_monitor_enable <= temp_monitor_enable_ff;
            o_output_voltage_code <= output_voltage_code_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // multi-step behaviours are spelled out as named sequences
    // a result pulse, one quiet cycle, then a read of the thermal register
    sequence s_cal_then_read;
        i_cal_done ##1 (!i_cal_done && !wr_tv) ##1 rd_tv;
    endsequence
    // a register write that no calibration result overrides in the same cycle
    sequence s_code_write;
        wr_tv && !i_cal_done;
    endsequence
    // a light request rising while the part is not shut down
    sequence s_light_request;
        $rose(sif.flash_req) && !over_temperature_flag_ff;
    endsequence

    // flag behaviour
    a_hot_set_wins: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        temp_monitor_enable_ff && hot_ff |=> over_temperature_flag_ff)
        else $error("hot flag not set");
    a_hot_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_tv && !i_wdata[6] && !(temp_monitor_enable_ff && hot_ff)
        |=> !over_temperature_flag_ff)
        else $error("hot flag not cleared");
    a_hot_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        over_temperature_flag_ff && !wr_tv |=> over_temperature_flag_ff)
        else $error("hot flag dropped");
    a_hot_needs_cmp: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !over_temperature_flag_ff && !(temp_monitor_enable_ff && hot_ff)
        |=> !over_temperature_flag_ff)
        else $error("hot flag set without comparator");
    a_warn_needs_cmp: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !temperature_warning_flag_ff && !(temp_monitor_enable_ff && warn_ff)
        |=> !temperature_warning_flag_ff)
        else $error("warn flag set without comparator");
    a_warn_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        temp_monitor_enable_ff && warn_ff |=> temperature_warning_flag_ff)
        else $error("warn flag not set");
    a_warn_rd_clr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        rd_tv && !(temp_monitor_enable_ff && warn_ff) |=> !temperature_warning_flag_ff)
        else $error("warn flag kept after read");

    // register port
    a_en_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_tv |=> temp_monitor_enable_ff == $past(i_wdata[7]) ##1 o_temp_monitor_enable
        == $past(i_wdata[7], 2))
        else $error("enable not written");
    a_code_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_code_write |=> (output_voltage_code_ff == $past(i_wdata[3:0]))
        ##1 (o_output_voltage_code == $past(i_wdata[3:0], 2)))
        else $error("target code not written");
    a_cal_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_cal_then_read |=> o_rdata[3:0] == $past(i_cal_code, 3))
        else $error("calibration code not returned");
    a_rev_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        rd_rev |=> o_rdata == {5'h00, ltvs_pkg::SI_REV_ID})
        else $error("bad revision read");
    a_other_read_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rd && !rd_tv && !rd_rev |=> o_rdata == ltvs_pkg::RD_ZERO)
        else $error("unmapped read not zero");

    // strobe gating and light outputs
    a_hdr_capture: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        flash_end |=> regulator_headroom_ok_ff == $past(hdr_ff))
        else $error("headroom not captured");
    a_hdr_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !flash_end |=> regulator_headroom_ok_ff == $past(regulator_headroom_ok_ff))
        else $error("headroom changed outside flash end");
    a_light_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_light_request |=> sif.flash_on)
        else $error("flash not started by request");
    a_torch_wdog_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        sb_ff && !over_temperature_flag_ff |=> sif.torch_on)
        else $error("torch dropped with strobe b high");
    a_shutdown_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        over_temperature_flag_ff |=> o_shutdown && !o_flash_on && !o_torch_on)
        else $error("light on in shutdown");
endmodule

/* File: logic/ltvs_pkg.sv */
// ltvs_pkg: register map, field positions, reset values and timing counts of the
// thermal / output-voltage register logic of the flash driver.
// assumes a byte-wide register port decoded by the serial interface elsewhere.
package ltvs_pkg;
    localparam logic [7:0] ADDR_THERM_VOUT   = 8'h06;
    localparam logic [7:0] ADDR_SI_REV       = 8'h07;
    localparam int         BIT_TEMP_MON_EN   = 7;
    localparam int         BIT_OVER_TEMP     = 6;
    localparam int         BIT_TEMP_WARN     = 5;
    localparam int         BIT_HEADROOM_OK   = 4;
    localparam logic [3:0] VOUT_CODE_RST     = 4'h9;
    // arbitrary neutral revision value
    localparam logic [2:0] SI_REV_ID         = 3'h1;
    localparam logic [7:0] RD_ZERO           = 8'h00;
    // safety timer: one tick per millisecond at 10 MHz
    localparam int         CLK_HZ            = 10_000_000;
    localparam int         TICK_US           = 1000;
    localparam int         TICK_CYC          = CLK_HZ / 1_000_000 * TICK_US;
    localparam logic [13:0] TICK_CYC_W       = 14'(TICK_CYC);
    // dc-light watchdog window in ticks
    localparam logic [15:0] WDOG_TICKS       = 16'h9c40;
    // millivolt table of the output voltage code
    function automatic logic [12:0] vout_mv(input logic [3:0] code);
        logic [12:0] mv;
        mv = 13'h0ef1 + 13'(code) * 13'h007d;
        if (code == 4'h1) begin
            mv = 13'h0feb;
        end else if (code == 4'hf) begin
            mv = 13'h1644;
        end
        return mv;
    endfunction
endpackage

/* File: logic/ltvs_strobe_if.sv */
// ltvs_strobe_if: synchronised strobe levels passed from the top to the flash sequencer.
// assumes the top module owns the synchronisers.
`timescale 1ns/1ps
interface ltvs_strobe_if;
    logic flash_req;
    logic torch_req;
    logic wdog_off;
    logic shutdown;
    logic [7:0] flash_safety_timer_ticks;
    logic tick;
    logic flash_on;
    logic torch_on;
    logic flash_end;
    modport ctrl (output flash_req, torch_req, wdog_off, shutdown, flash_safety_timer_ticks, tick,
                  input  flash_on, torch_on, flash_end);
    modport seq  (input  flash_req, torch_req, wdog_off, shutdown, flash_safety_timer_ticks, tick,
                  output flash_on, torch_on, flash_end);
endinterface

/* File: logic/ltvs_flash_seq.sv */
// ltvs_flash_seq: flash / torch sequencer with safety timer and torch watchdog.
// assumes synchronised requests and a one-cycle tick from the top.
`timescale 1ns/1ps
module ltvs_flash_seq (
    input  wire logic   i_clk,
    input  wire logic   i_rst_n,
    ltvs_strobe_if.seq  s
);
    typedef enum logic [1:0] {LTVS_IDLE, LTVS_FLASH, LTVS_HOLD} ltvs_st_t;
    ltvs_st_t    st_ff;
    logic [7:0]  flash_safety_timer_cnt_ff;
    logic [15:0] wdog_cnt_ff;
    logic        end_ff;
    logic        torch_ff;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff       <= LTVS_IDLE;
            flash_safety_timer_cnt_ff <= 8'h00;
            end_ff      <= 1'b0;
        end else begin
            end_ff <= 1'b0;
            case (st_ff)
                LTVS_IDLE: begin
                    flash_safety_timer_cnt_ff <= 8'h00;
                    if (s.flash_req && !s.shutdown) begin
                        st_ff <= LTVS_FLASH;
                    end
                end
                LTVS_FLASH: begin
                    if (s.tick) begin
                        flash_safety_timer_cnt_ff <= flash_safety_timer_cnt_ff + 8'h01;
                    end
                    // safety timer bounds the flash length
                    if (!s.flash_req || s.shutdown ||
                        (s.tick && flash_safety_timer_cnt_ff + 8'h01 >= s.flash_safety_timer_ticks)) begin
                        end_ff <= 1'b1;
                        st_ff  <= s.flash_req ? LTVS_HOLD : LTVS_IDLE;
                    end
                end
                LTVS_HOLD: begin
                    // a timed-out strobe must drop before the next flash
                    if (!s.flash_req) begin
                        st_ff <= LTVS_IDLE;
                    end
                end
                default: st_ff <= LTVS_IDLE;
            endcase
        end
    end

    // torch watchdog, held at zero while strobe b is high
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wdog_cnt_ff <= 16'h0000;
            torch_ff    <= 1'b0;
        end else if (!s.torch_req || s.shutdown) begin
            wdog_cnt_ff <= 16'h0000;
            torch_ff    <= 1'b0;
        end else if (s.wdog_off) begin
            wdog_cnt_ff <= 16'h0000;
            torch_ff    <= 1'b1;
        end else if (wdog_cnt_ff >= ltvs_pkg::WDOG_TICKS) begin
            torch_ff    <= 1'b0;
        end else begin
            torch_ff    <= 1'b1;
            if (s.tick) begin
                wdog_cnt_ff <= wdog_cnt_ff + 16'h0001;
            end
        end
    end

    assign s.flash_on  = (st_ff == LTVS_FLASH);
    assign s.torch_on  = torch_ff;
    assign s.flash_end = end_ff;
endmodule

/* File: testbench/ltvs_far_model.sv */
// ltvs_far_model: camera-module strobe lines, thermistor comparators, headroom
// comparator and calibration engine that sit around the register block.
// assumes the caller changes nothing except through these tasks, on falling edges.
`timescale 1ns/1ps
module ltvs_far_model (
    input  wire logic       i_clk,
    output logic            o_strobe_a,
    output logic            o_strobe_b,
    output logic            o_hot,
    output logic            o_warn,
    output logic            o_headroom,
    output logic [3:0]      o_cal_code,
    output logic            o_cal_done
);
    initial begin
        o_strobe_a = 1'b0;
        o_strobe_b = 1'b0;
        o_hot      = 1'b0;
        o_warn     = 1'b0;
        o_headroom = 1'b0;
        o_cal_code = 4'h0;
        o_cal_done = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic set_strobe(input logic a, input logic b, input logic hdr);
        @(negedge i_clk);
        o_strobe_a = a;
        o_strobe_b = b;
        o_headroom = hdr;
    endtask
    // long enough to pass the four-edge synchroniser, then released again
    task automatic cmp_pulse(input logic hot, input logic warn);
        @(negedge i_clk);
        o_hot  = hot;
        o_warn = warn;
        repeat (8) @(negedge i_clk);
        o_hot  = 1'b0;
        o_warn = 1'b0;
        repeat (8) @(negedge i_clk);
    endtask
    // code is only valid with done; afterwards it is scrambled so nothing leans on it
    task automatic cal_result(input logic [3:0] code);
        @(negedge i_clk);
        o_cal_code = code;
        o_cal_done = 1'b1;
        @(negedge i_clk);
        o_cal_done = 1'b0;
        o_cal_code = ~code;
    endtask
endmodule

/* File: testbench/led_thermal_voltage_status_regs_tb.sv */
// led_thermal_voltage_status_regs_tb: register read/write sequences with expected
// values; assumes the byte register port and 10 MHz clock of the register block.
`timescale 1ns/1ps
module led_thermal_voltage_status_regs_tb;
    logic       i_clk;
    logic       i_rst_n;
    logic [7:0] i_addr;
    logic [7:0] i_wdata;
    logic       i_wr;
    logic       i_rd;
    logic       i_sw_flash;
    logic       i_sw_torch;
    logic [7:0] i_flash_safety_timer_ticks;
    logic       sa, sb, hot, warn, hdr, cal_done;
    logic [3:0] cal_code;
    logic [7:0] o_rdata;
    logic       o_temp_monitor_enable, o_shutdown, o_flash_on, o_torch_on;
    logic [3:0] o_output_voltage_code;
    logic [7:0] rev;
    int         failures, n_checks, cyc, k;

    ltvs_regs dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_hot_cmp(hot), .i_warn_cmp(warn), .i_headroom_cmp(hdr),
        .i_cal_code(cal_code), .i_cal_done(cal_done), .i_strobe_input_a(sa),
        .i_strobe_input_b(sb), .i_sw_flash(i_sw_flash), .i_sw_torch(i_sw_torch),
        .i_flash_safety_timer_ticks(i_flash_safety_timer_ticks), .o_rdata(o_rdata),
        .o_temp_monitor_enable(o_temp_monitor_enable), .o_shutdown(o_shutdown),
        .o_output_voltage_code(o_output_voltage_code), .o_flash_on(o_flash_on),
        .o_torch_on(o_torch_on));
    ltvs_far_model far (.i_clk(i_clk), .o_strobe_a(sa), .o_strobe_b(sb), .o_hot(hot),
        .o_warn(warn), .o_headroom(hdr), .o_cal_code(cal_code), .o_cal_done(cal_done));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc >= 60000) begin
            failures++;
            $display("timeout at %0t", $time);
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // outputs follow two cycles after the write strobe, so wait them out here
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_addr  = a;
        i_wdata = d;
        i_wr    = 1'b1;
        @(negedge i_clk);
        i_wr = 1'b0;
        repeat (2) @(negedge i_clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_clk);
        i_addr = a;
        i_rd   = 1'b1;
        @(negedge i_clk);
        i_rd = 1'b0;
        @(negedge i_clk);
        chk(o_rdata, exp);
    endtask
    task automatic wait_flash(input logic lvl);
        for (k = 0; k < 12 && o_flash_on !== lvl; k++) @(negedge i_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_rst_n      = 1'b0;
        i_addr       = 8'h00;
        i_wdata      = 8'h00;
        i_wr         = 1'b0;
        i_rd         = 1'b0;
        i_sw_flash   = 1'b0;
        i_sw_torch   = 1'b0;
        i_flash_safety_timer_ticks = 8'h02;
        failures     = 0;
        n_checks     = 0;
        cyc          = 0;
        rev = {5'b0_0000, ltvs_pkg::SI_REV_ID};
        repeat (12) @(negedge i_clk);
        i_rst_n = 1'b1;
        rd_chk(8'h06, 8'h09);
        chk({4'h0, o_output_voltage_code}, 8'h09);
        rd_chk(8'h07, rev);
        rd_chk(8'h08, 8'h00);
        reg_wr(8'h07, 8'hff);
        rd_chk(8'h07, rev);
        $display("test reset_and_revision done");
        // monitoring off: comparators must leave the flags alone
        far.cmp_pulse(1'b1, 1'b1);
        rd_chk(8'h06, 8'h09);
        chk({7'h00, o_shutdown}, 8'h00);
        // host enables monitoring (voltage mode taken as on), then walks every code
        for (int c = 0; c < 16; c++) begin
            reg_wr(8'h06, {4'h8, 4'(c)});
            chk({4'h0, o_output_voltage_code}, 8'(c));
            chk({7'h00, o_temp_monitor_enable}, 8'h01);
            rd_chk(8'h06, {4'h8, 4'(c)});
        end
        far.cal_result(4'h3);
        rd_chk(8'h06, 8'h83);
        $display("test codes_and_calibration done");
        far.cmp_pulse(1'b0, 1'b1);
        rd_chk(8'h06, 8'ha3);
        rd_chk(8'h06, 8'h83);
        $display("test warning done");
        far.cmp_pulse(1'b1, 1'b0);
        rd_chk(8'h06, 8'hc3);
        chk({7'h00, o_shutdown}, 8'h01);
        reg_wr(8'h06, 8'hc3);
        far.set_strobe(1'b1, 1'b0, 1'b1);
        repeat (12) @(negedge i_clk);
        chk({7'h00, o_flash_on}, 8'h00);
        chk({7'h00, o_shutdown}, 8'h01);
        far.set_strobe(1'b0, 1'b0, 1'b1);
        // let the released strobe pass the synchroniser, or the clear would start a flash
        repeat (6) @(negedge i_clk);
        reg_wr(8'h06, 8'h83);
        chk({7'h00, o_shutdown}, 8'h00);
        rd_chk(8'h06, 8'h83);
        $display("test hot_shutdown done");
        // headroom is good then poor across two strobes
        for (int h = 1; h >= 0; h--) begin
            far.set_strobe(1'b1, 1'b0, 1'(h));
            wait_flash(1'b1);
            chk({7'h00, o_flash_on}, 8'h01);
            far.set_strobe(1'b0, 1'b0, 1'(h));
            wait_flash(1'b0);
            chk({7'h00, o_flash_on}, 8'h00);
            rd_chk(8'h06, {3'b100, 1'(h), 4'h3});
        end
        @(negedge i_clk);
        i_sw_flash = 1'b1;
        wait_flash(1'b1);
        chk({7'h00, o_flash_on}, 8'h01);
        i_sw_flash = 1'b0;
        i_sw_torch = 1'b1;
        repeat (12) @(negedge i_clk);
        chk({7'h00, o_torch_on}, 8'h01);
        i_sw_torch = 1'b0;
        // the torch watchdog window is far beyond this run; only the pin path shows
        far.set_strobe(1'b0, 1'b1, 1'b0);
        repeat (12) @(negedge i_clk);
        chk({7'h00, o_torch_on}, 8'h01);
        far.set_strobe(1'b0, 1'b0, 1'b0);
        $display("test strobe_paths done");
        // two-tick timer ends between one and two ticks, held strobe notwithstanding
        far.set_strobe(1'b1, 1'b0, 1'b0);
        repeat (5000) @(negedge i_clk);
        chk({7'h00, o_flash_on}, 8'h01);
        repeat (20000) @(negedge i_clk);
        chk({7'h00, o_flash_on}, 8'h00);
        far.set_strobe(1'b0, 1'b0, 1'b0);
        $display("test safety_timer done");
        stop_test();
    end
endmodule
